// >>> src/hpp_pkg.sv
// hpp_pkg: constants for the parallel host port block
// assumes an apb slave at 10 MHz and pins sampled on core_clk
package hpp_pkg;
    // ****************************************************************
    // apb register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;   // port control, 16 bits
    localparam logic [7:0] OFF_DDIR = 8'h04;   // gpio direction
    localparam logic [7:0] OFF_GOUT = 8'h08;   // gpio output data
    localparam logic [7:0] OFF_GIN = 8'h0C;    // gpio pin levels
    localparam logic [7:0] OFF_CRX = 8'h10;    // core-side receive word
    localparam logic [7:0] OFF_CTX = 8'h14;    // core-side transmit word
    localparam logic [7:0] OFF_STAT = 8'h18;   // flags
    localparam logic [7:0] OFF_VEC = 8'h1C;    // host vector / command
    // ****************************************************************
    // port control fields
    // ****************************************************************
    localparam int CB_HOSTEN = 0;      // host function, else gpio
    localparam int CB_MUX = 1;         // multiplexed bus
    localparam int CB_DBLSTB = 2;      // double data strobe
    localparam int CB_DBLREQ = 3;      // double request
    localparam int CB_ASPOL = 4;       // address strobe active high
    localparam int CB_CSPOL = 5;       // chip select active high
    localparam int CB_DSPOL = 6;       // data/read strobe active high
    localparam int CB_WRPOL = 7;       // write strobe active high
    localparam int CB_REQPOL = 8;      // request outputs active high
    localparam int CB_REQOD = 9;       // request outputs open drain
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // ****************************************************************
    // host-side register index (low three address bits)
    // ****************************************************************
    localparam logic [2:0] HA_VEC = 3'h1;
    localparam logic [2:0] HA_STAT = 3'h2;
    localparam logic [2:0] HA_HIGH = 3'h5;
    localparam logic [2:0] HA_MID = 3'h6;
    localparam logic [2:0] HA_LOW = 3'h7;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 24;
endpackage : hpp_pkg

// >>> src/hpp_pin_cell.sv
// hpp_pin_cell: one group of shared pins, host or gpio use
// assumes the caller chooses the function per cell
`timescale 1ns/1ps
module hpp_pin_cell #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hostFn,
    input wire logic [W-1:0] hostOut,
    input wire logic hostOe,
    input wire logic [W-1:0] gpioDir,
    input wire logic [W-1:0] gpioOut,
    input wire logic [W-1:0] padIn,
    output logic [W-1:0] padOut,
    output logic [W-1:0] padOe,
    output logic [W-1:0] padSample
);
    // registered pin drive, host function or gpio for the whole cell
    always_ff @(posedge core_clk) begin
        if (reset) begin
            padOut <= '0;
            padOe <= '0;
            padSample <= '0;
        end else begin
            padOut <= hostFn ? hostOut : gpioOut;
            padOe <= hostFn ? {W{hostOe}} : gpioDir;
            padSample <= padIn;
        end
    end
endmodule : hpp_pin_cell

// >>> src/hpp_host_port.sv
// hpp_host_port: byte-wide host port with apb port control
// assumes host pins synchronous to core_clk, single clock domain
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module hpp_host_port (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] hostDataOut,
    output logic [7:0] hostDataOe,
    input wire logic [2:0] hostAddrIn,
    input wire logic hostAddressStrobe,
    input wire logic hostChipSelect,
    input wire logic hostReadWriteSelect,
    input wire logic hostDataStrobe,
    output logic [2:0] ctlPinOut,
    output logic [2:0] ctlPinOe,
    output logic hostRequestOut,
    output logic hostRequestOe,
    output logic hostRxRequestOut,
    output logic hostRxRequestOe,
    output logic [7:0] hostVectorReg,
    output logic coreRxValid
);
    // ****************************************************************
    // apb register file
    // ****************************************************************
    logic [15:0] ctrl_q;
    logic [15:0] ddir_q;
    logic [15:0] gout_q;
    logic [23:0] crx_q;     // core-side receive register
    logic [23:0] txw_q;     // core to host word (rx bytes)
    logic rxFull_q;         // host rx byte registers full
    logic txEmpty_q;        // host tx byte registers empty
    logic [23:0] htx_q;     // host written tx bytes
    logic [7:0] vec_q;
    logic cmd_q;            // host command bit
    logic [15:0] padSample;
    logic [7:0] hSample;
    logic apbWr;
    logic apbRd;
    logic hostFn;
    logic mux;
    logic dbl;
    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign hostFn = ctrl_q[hpp_pkg::CB_HOSTEN];
    assign mux = ctrl_q[hpp_pkg::CB_MUX];
    assign dbl = ctrl_q[hpp_pkg::CB_DBLSTB];
    assign hostVectorReg = vec_q;

    // address decode helper
    function automatic logic known(input logic [7:0] a);
        known = (a <= hpp_pkg::OFF_VEC) && (a[1:0] == 2'b00);
    endfunction : known

    // polarity helper: level to active given high-active select
    function automatic logic act(input logic lvl, input logic hi);
        act = hi ? lvl : !lvl;
    endfunction : act

    // ****************************************************************
    // host strobe decode
    // ****************************************************************
    logic asAct;
    logic csAct;
    logic rdAct;
    logic wrAct;
    logic dsPrev_q;
    logic [10:0] hAddr;
    logic [7:0] latLow_q;   // muxed low address byte
    logic [2:0] latHigh_q;  // muxed upper address bits
    logic accRd;
    logic accWr;
    logic strobeOn;
    // address strobe and chip select with programmable sense
    assign asAct = act(hostAddressStrobe, ctrl_q[hpp_pkg::CB_ASPOL]);
    assign csAct = act(hostChipSelect, ctrl_q[hpp_pkg::CB_CSPOL]);
    // strobe styles: single strobe with r/w, or separate rd and wr
    always_comb begin
        if (dbl) begin
            rdAct = act(hostReadWriteSelect, ctrl_q[hpp_pkg::CB_DSPOL]);
            wrAct = act(hostDataStrobe, ctrl_q[hpp_pkg::CB_WRPOL]);
            strobeOn = rdAct || wrAct;
        end else begin
            strobeOn = act(hostDataStrobe, ctrl_q[hpp_pkg::CB_DSPOL]);
            rdAct = strobeOn && hostReadWriteSelect;
            wrAct = strobeOn && !hostReadWriteSelect;
        end
    end
    // select gating and address source per bus mode
    assign accRd = hostFn && rdAct && (mux || csAct);
    assign accWr = hostFn && wrAct && (mux || csAct);
    assign hAddr = mux ? {latHigh_q, latLow_q}
                       : {8'h00, hostAddrIn};

    // muxed address latch samples every cycle while address strobe is active
    always_ff @(posedge core_clk) begin
        if (reset) begin
            latLow_q <= '0;
            latHigh_q <= '0;
        end else begin
            if (hostFn && mux && asAct) begin
                latLow_q <= hostDataIn;
                latHigh_q <= hostAddrIn;
            end
            // last sample while active is what stays held
        end
    end

    // write edge detect: a host write completes on strobe release
    logic wrPrev_q;
    logic [7:0] wrByte_q;
    logic wrDone;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrPrev_q <= 1'b0;
            wrByte_q <= '0;
            dsPrev_q <= 1'b0;
        end else begin
            wrPrev_q <= accWr;
            dsPrev_q <= strobeOn;
            if (accWr) begin
                wrByte_q <= hostDataIn;
            end
        end
    end
    assign wrDone = wrPrev_q && !accWr;

    // ****************************************************************
    // host-visible byte registers and flags
    // ****************************************************************
    logic [7:0] rdByte;
    logic lowRead;
    assign lowRead = accRd && (hAddr[2:0] == hpp_pkg::HA_LOW);
    always_comb begin
        unique case (hAddr[2:0])
            hpp_pkg::HA_HIGH: rdByte = txw_q[23:16];
            hpp_pkg::HA_MID: rdByte = txw_q[15:8];
            hpp_pkg::HA_LOW: rdByte = txw_q[7:0];
            hpp_pkg::HA_STAT: rdByte = {6'h00, txEmpty_q, rxFull_q};
            hpp_pkg::HA_VEC: rdByte = vec_q;
            default: rdByte = 8'h00;
        endcase
    end

    // host write side: tx bytes, vector and command
    logic ctxWr;
    logic crxRd;
    logic vecWr;
    assign ctxWr = apbWr && paddr == hpp_pkg::OFF_CTX;
    assign crxRd = apbRd && paddr == hpp_pkg::OFF_CRX;
    assign vecWr = apbWr && paddr == hpp_pkg::OFF_VEC;
    logic hostLow;
    assign hostLow = wrDone && hAddr[2:0] == hpp_pkg::HA_LOW;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            htx_q <= '0;
            vec_q <= '0;
            cmd_q <= 1'b0;
        end else begin
            if (wrDone) begin
                unique case (hAddr[2:0])
                    hpp_pkg::HA_HIGH: htx_q[23:16] <= wrByte_q;
                    hpp_pkg::HA_MID: htx_q[15:8] <= wrByte_q;
                    hpp_pkg::HA_LOW: htx_q[7:0] <= wrByte_q;
                    hpp_pkg::HA_VEC: begin
                        vec_q <= wrByte_q[6:0] == 7'h00 ? vec_q
                                 : {1'b0, wrByte_q[6:0]};
                        cmd_q <= wrByte_q[7];   // command request
                    end
                    default: ;
                endcase
            end
            // core clears command; a new host set wins
            if (vecWr && pwdata[0] && !(wrDone
                    && hAddr[2:0] == hpp_pkg::HA_VEC && wrByte_q[7])) begin
                cmd_q <= 1'b0;
            end
        end
    end

    // low byte write hands the word to the core side receive register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            crx_q <= '0;
            txEmpty_q <= 1'b1;
            coreRxValid <= 1'b0;
        end else begin
            if (hostLow) begin
                crx_q <= {htx_q[23:8], wrByte_q};
                coreRxValid <= 1'b1;
            end else if (crxRd) begin
                coreRxValid <= 1'b0;
            end
            // empty again once the core has taken the word
            if (hostLow) begin
                txEmpty_q <= 1'b0;
            end else if (crxRd) begin
                txEmpty_q <= 1'b1;
            end
        end
    end

    // core loads a word for the host; host low-byte read empties it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            txw_q <= '0;
            rxFull_q <= 1'b0;
        end else begin
            if (ctxWr) begin
                txw_q <= pwdata[23:0];
            end
            if (ctxWr) begin
                rxFull_q <= 1'b1;
            end else if (lowRead && !dsPrev_q) begin
                rxFull_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // request outputs
    // ****************************************************************
    logic reqA;
    logic reqB;
    logic reqHi;
    logic reqOd;
    assign reqHi = ctrl_q[hpp_pkg::CB_REQPOL];
    assign reqOd = ctrl_q[hpp_pkg::CB_REQOD];
    assign reqA = ctrl_q[hpp_pkg::CB_DBLREQ] ? txEmpty_q
                                             : (txEmpty_q || rxFull_q);
    assign reqB = rxFull_q;
    // polarity then open-drain: drive only the low pin level
    always_comb begin
        hostRequestOut = reqHi ? reqA : !reqA;
        hostRequestOe = hostFn && (!reqOd || !hostRequestOut);
        hostRxRequestOut = reqHi ? reqB : !reqB;
        hostRxRequestOe = hostFn && ctrl_q[hpp_pkg::CB_DBLREQ]
                          && (!reqOd || !hostRxRequestOut);
    end

    // ****************************************************************
    // pins: shared data byte and three control pins
    // ****************************************************************
    hpp_pin_cell #(.W(8)) u_data (
        .core_clk(core_clk),
        .reset(reset),
        .hostFn(hostFn),
        .hostOut(rdByte),
        .hostOe(accRd),
        .gpioDir(ddir_q[7:0]),
        .gpioOut(gout_q[7:0]),
        .padIn(hostDataIn),
        .padOut(hostDataOut),
        .padOe(hostDataOe),
        .padSample(hSample)
    );
    // control pins are inputs in host mode, gpio otherwise
    hpp_pin_cell #(.W(3)) u_ctl (
        .core_clk(core_clk),
        .reset(reset),
        .hostFn(hostFn),
        .hostOut(3'h0),
        .hostOe(1'b0),
        .gpioDir(ddir_q[10:8]),
        .gpioOut(gout_q[10:8]),
        .padIn(hostAddrIn),
        .padOut(ctlPinOut),
        .padOe(ctlPinOe),
        .padSample(padSample[10:8])
    );
    assign padSample[7:0] = hSample;
    assign padSample[15:11] = '0;

    // ****************************************************************
    // apb writes and read mux
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q <= hpp_pkg::CTRL_RST;
            ddir_q <= '0;
            gout_q <= '0;
        end else if (apbWr) begin
            unique case (paddr)
                hpp_pkg::OFF_CTRL: ctrl_q <= pwdata[15:0];
                hpp_pkg::OFF_DDIR: ddir_q <= pwdata[15:0];
                hpp_pkg::OFF_GOUT: gout_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end
    always_comb begin
        pslverr = psel && penable && !known(paddr);
        unique case (paddr)
            hpp_pkg::OFF_CTRL: prdata = {16'h0000, ctrl_q};
            hpp_pkg::OFF_DDIR: prdata = {16'h0000, ddir_q};
            hpp_pkg::OFF_GOUT: prdata = {16'h0000, gout_q};
            hpp_pkg::OFF_GIN: prdata = {16'h0000, padSample};
            hpp_pkg::OFF_CRX: prdata = {8'h00, crx_q};
            hpp_pkg::OFF_CTX: prdata = {8'h00, txw_q};
            hpp_pkg::OFF_STAT: prdata = {29'h0, coreRxValid, txEmpty_q,
                                         rxFull_q};
            hpp_pkg::OFF_VEC: prdata = {23'h0, cmd_q, vec_q};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_lowWrite;
        hostLow;
    endsequence
    chk_rx_handoff: assert property (@(posedge core_clk) disable iff (reset)
        s_lowWrite |=> coreRxValid && !txEmpty_q)
        else $error("transmit bytes not handed to core");
    chk_ctx_full: assert property (@(posedge core_clk) disable iff (reset)
        ctxWr |=> rxFull_q && txw_q == $past(pwdata[23:0]))
        else $error("rx full flag not set on core load");
    chk_gpio_dir: assert property (@(posedge core_clk) disable iff (reset)
        !hostFn ##1 !hostFn |-> hostDataOe == $past(ddir_q[7:0]))
        else $error("gpio direction wrong");
    chk_host_drive: assert property (@(posedge core_clk) disable iff (reset)
        hostFn && !accRd ##1 hostFn |-> hostDataOe == 8'h00)
        else $error("data pins driven outside a read");
    chk_req_single: assert property (@(posedge core_clk) disable iff (reset)
        !ctrl_q[hpp_pkg::CB_DBLREQ] && !reqHi
        |-> hostRequestOut == !(txEmpty_q || rxFull_q))
        else $error("single request level wrong");
    chk_req_od: assert property (@(posedge core_clk) disable iff (reset)
        reqOd && hostRequestOut |-> !hostRequestOe)
        else $error("open drain request drove high");
    chk_cs_gate: assert property (@(posedge core_clk) disable iff (reset)
        hostFn && !mux && !csAct |-> !accRd && !accWr)
        else $error("access without chip select");
    chk_ctrl_rst: assert property (@(posedge core_clk)
        !reset && $past(reset) |-> ctrl_q == hpp_pkg::CTRL_RST)
        else $error("port control reset value wrong");
endmodule : hpp_host_port

// >>> tb/hpp_host_model.sv
// hpp_host_model: external host running byte accesses on the host port
// assumes pins sampled on core_clk and port control mirrored by the bench
`timescale 1ns/1ps
module hpp_host_model (
    input wire logic core_clk,
    input wire logic [15:0] ctrlMode,
    input wire logic [7:0] padLevel,
    output logic [7:0] busOut,
    output logic [2:0] addrOut,
    output logic addrStb,
    output logic chipSel,
    output logic rwSel,
    output logic dataStb
);
    logic csOn = 1'b0;
    logic asOn = 1'b0;
    logic rdOn = 1'b0;
    logic wrOn = 1'b0;
    logic driveOn = 1'b0;
    logic [7:0] driveVal = 8'h00;
    logic [7:0] floatPat = 8'h5A;
    logic dbl;
    initial addrOut = 3'h0;
    // released data lines show a pattern that moves every cycle
    always @(posedge core_clk) begin
        floatPat <= ~{floatPat[6:0], floatPat[7]};
    end
    // pin levels from access state and programmed polarity
    assign dbl = ctrlMode[hpp_pkg::CB_DBLSTB];
    assign busOut = driveOn ? driveVal : floatPat;
    assign chipSel = csOn ^ ~ctrlMode[hpp_pkg::CB_CSPOL];
    assign addrStb = asOn ^ ~ctrlMode[hpp_pkg::CB_ASPOL];
    assign dataStb = dbl ? wrOn ^ ~ctrlMode[hpp_pkg::CB_WRPOL]
        : (rdOn | wrOn) ^ ~ctrlMode[hpp_pkg::CB_DSPOL];
    assign rwSel = dbl ? rdOn ^ ~ctrlMode[hpp_pkg::CB_DSPOL]
        : ~wrOn;
    // one host access; muxed mode sends the address byte first
    task automatic access(input logic rd, input logic [2:0] idx,
            input logic [7:0] wd, output logic [7:0] rv);
        rv = 8'h00;
        @(posedge core_clk);
        addrOut <= 3'h0;
        if (ctrlMode[hpp_pkg::CB_MUX]) begin
            driveOn <= 1'b1;
            driveVal <= {5'h00, idx};
            asOn <= 1'b1;
            @(posedge core_clk);
            asOn <= 1'b0;
            @(posedge core_clk);
        end else begin
            addrOut <= idx;
        end
        driveOn <= ~rd;
        driveVal <= wd;
        csOn <= 1'b1;
        rdOn <= rd;
        wrOn <= ~rd;
        @(posedge core_clk);
        if (rd) begin
            repeat (2) @(posedge core_clk);
            rv = padLevel;
        end
        csOn <= 1'b0;
        rdOn <= 1'b0;
        wrOn <= 1'b0;
        driveOn <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : access
    // drive every data line with a steady value
    task automatic holdBus(input logic [7:0] v);
        @(posedge core_clk);
        driveOn <= 1'b1;
        driveVal <= v;
    endtask : holdBus
endmodule : hpp_host_model

// >>> tb/tb.sv
// tb: apb and host-side tests of the parallel host port
// assumes hpp_host_model as the host and a 10 MHz core_clk
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] MODES [9] = '{16'h0001, 16'h0003, 16'h0005,
        16'h00F5, 16'h0073, 16'h0301, 16'h0201, 16'h0009, 16'h0309};
    localparam logic [2:0] IDX [3] = '{hpp_pkg::HA_HIGH, hpp_pkg::HA_MID,
        hpp_pkg::HA_LOW};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, coreRxValid;
    logic [7:0] hostDataIn, hostDataOut, hostDataOe, hostBus, hostVectorReg;
    logic [2:0] hostAddrIn, ctlPinOut, ctlPinOe, modelAddr;
    logic hostAddressStrobe, hostChipSelect, hostReadWriteSelect;
    logic hostDataStrobe, hostRequestOut, hostRequestOe;
    logic hostRxRequestOut, hostRxRequestOe;
    logic [15:0] ctrlMirror = 16'h0000;
    logic [31:0] q;
    logic err;
    logic [7:0] hb;
    logic [23:0] w;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    // wires resolved from the port's enables, the host model fills the rest
    assign hostDataIn = (hostDataOe & hostDataOut) | (~hostDataOe & hostBus);
    assign hostAddrIn = (ctlPinOe & ctlPinOut) | (~ctlPinOe & modelAddr);
    // clock and hang limit
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            $display("[ERR] timeout expected done seen hang");
            bad_count++;
            give_verdict();
        end
    end
    hpp_host_port u_hpp_host_port (.core_clk(core_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hostDataIn(hostDataIn),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .hostAddrIn(hostAddrIn), .hostAddressStrobe(hostAddressStrobe),
        .hostChipSelect(hostChipSelect),
        .hostReadWriteSelect(hostReadWriteSelect),
        .hostDataStrobe(hostDataStrobe), .ctlPinOut(ctlPinOut),
        .ctlPinOe(ctlPinOe), .hostRequestOut(hostRequestOut),
        .hostRequestOe(hostRequestOe), .hostRxRequestOut(hostRxRequestOut),
        .hostRxRequestOe(hostRxRequestOe), .hostVectorReg(hostVectorReg),
        .coreRxValid(coreRxValid));
    hpp_host_model u_hpp_host_model (.core_clk(core_clk),
        .ctrlMode(ctrlMirror), .padLevel(hostDataIn), .busOut(hostBus),
        .addrOut(modelAddr), .addrStb(hostAddressStrobe),
        .chipSel(hostChipSelect), .rwSel(hostReadWriteSelect),
        .dataStb(hostDataStrobe));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string n, input logic [31:0] e,
            input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && a == hpp_pkg::OFF_CTRL) ctrlMirror <= d[15:0];
    endtask : apb
    task automatic rdChk(input string n, input logic [7:0] a,
            input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(n, x, q);
        check({n, " err"}, 32'h0, err);
    endtask : rdChk
    task automatic pinChk(input string n, input logic act, input logic o,
            input logic oe);
        logic lvl;
        logic oeExp;
        lvl = act ^ ~ctrlMirror[hpp_pkg::CB_REQPOL];
        oeExp = ctrlMirror[hpp_pkg::CB_HOSTEN]
                && (ctrlMirror[hpp_pkg::CB_REQOD] ? ~lvl : 1'b1);
        check({n, " enable"}, oeExp, oe);
        if (oeExp) check(n, lvl, o);
    endtask : pinChk
    task automatic reqChk(input logic txE, input logic rxF);
        @(negedge core_clk);
        if (ctrlMirror[hpp_pkg::CB_DBLREQ]) begin
            pinChk("tx request", txE, hostRequestOut, hostRequestOe);
            pinChk("rx request", rxF, hostRxRequestOut, hostRxRequestOe);
        end else begin
            pinChk("request", txE | rxF, hostRequestOut, hostRequestOe);
            check("rx request enable", 32'h0, hostRxRequestOe);
        end
    endtask : reqChk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rdChk("ctrl reset", hpp_pkg::OFF_CTRL, 32'h0);
        rdChk("status reset", hpp_pkg::OFF_STAT, 32'h2);
        reqChk(1'b1, 1'b0);
        check("data oe reset", 8'h00, hostDataOe);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped err", 1'b1, err);
        check("unmapped data", 32'h0, q);
        $display("reset and map test done");
        for (int i = 0; i < 9; i++) begin
            w = 24'(24'h3CA501 + 24'h111111 * i);
            apb(1'b1, hpp_pkg::OFF_CTRL, {16'h0, MODES[i]});
            rdChk("ctrl", hpp_pkg::OFF_CTRL, {16'h0, MODES[i]});
            rdChk("status empty", hpp_pkg::OFF_STAT, 32'h2);
            for (int b = 0; b < 3; b++) begin
                u_hpp_host_model.access(1'b0, IDX[b], w[23-8*b -: 8], hb);
            end
            reqChk(1'b0, 1'b0);
            check("core valid", 1'b1, coreRxValid);
            rdChk("status loaded", hpp_pkg::OFF_STAT, 32'h4);
            rdChk("core rx word", hpp_pkg::OFF_CRX, {8'h0, w});
            rdChk("status drained", hpp_pkg::OFF_STAT, 32'h2);
            apb(1'b1, hpp_pkg::OFF_CTX, {8'h0, ~w});
            rdChk("status full", hpp_pkg::OFF_STAT, 32'h3);
            reqChk(1'b1, 1'b1);
            for (int b = 0; b < 3; b++) begin
                u_hpp_host_model.access(1'b1, IDX[b], 8'h00, hb);
                check("host rx byte", {24'h0, ~w[23-8*b -: 8]}, hb);
            end
            rdChk("status read", hpp_pkg::OFF_STAT, 32'h2);
            reqChk(1'b1, 1'b0);
            $display("mode %h test done", MODES[i]);
        end
        apb(1'b1, hpp_pkg::OFF_CTRL, 32'h1);
        u_hpp_host_model.access(1'b0, hpp_pkg::HA_VEC, 8'h85, hb);
        check("vector", 7'h05, hostVectorReg[6:0]);
        rdChk("vector cmd set", hpp_pkg::OFF_VEC, 32'h105);
        apb(1'b1, hpp_pkg::OFF_VEC, 32'h1);
        rdChk("vector cmd clear", hpp_pkg::OFF_VEC, 32'h005);
        u_hpp_host_model.access(1'b0, hpp_pkg::HA_VEC, 8'h92, hb);
        check("vector again", 7'h12, hostVectorReg[6:0]);
        $display("vector test done");
        apb(1'b1, hpp_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, hpp_pkg::OFF_DDIR, 32'h50F);
        apb(1'b1, hpp_pkg::OFF_GOUT, 32'h3A5);
        u_hpp_host_model.holdBus(8'h3C);
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        check("gpio oe", 8'h0F, hostDataOe);
        check("gpio out", 4'h5, hostDataOut[3:0]);
        check("gpio ctl oe", 3'b101, ctlPinOe);
        check("gpio ctl out", 3'b001, ctlPinOut & 3'b101);
        apb(1'b0, hpp_pkg::OFF_GIN, 32'h0);
        check("gpio pins", 8'h35, q[7:0]);
        check("gpio ctl pins", 3'b001, q[10:8]);
        $display("gpio test done");
        give_verdict();
    end
endmodule : tb
